// >>> rsd_density_check.sv
`default_nettype none

module rsd_density_check #(
    parameter int MAX_BITS = rsd_pkg::DENSITY_MAX_BITS
) (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic enable,
    input  wire logic bit_strobe,
    input  wire logic data_bit,
    output logic      density_fault
);
    import rsd_pkg::*;

    localparam int CNT_W = $clog2(MAX_BITS + 2);
    localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(MAX_BITS);

    logic             last_bit_r;
    logic [CNT_W-1:0] run_r;

    ////////////////////////////////////////////////////////////////////
    // Run length of identical bits; saturates one past the limit.

    always_ff @(posedge mclk) begin
        if (rst || !enable) begin
            last_bit_r <= 1'b0;
            run_r      <= '0;
        end else if (bit_strobe) begin
            last_bit_r <= data_bit;
            if (data_bit != last_bit_r) begin
                run_r <= '0;
            end else if (run_r <= CNT_MAX) begin
                run_r <= run_r + 1'b1;
            end
        end
    end

    assign density_fault = (run_r > CNT_MAX);

endmodule : rsd_density_check

`default_nettype wire

// >>> rsd_link_monitor.sv
// The register addresses and the strobed register port were left to the implementer.
`default_nettype none

module rsd_link_monitor #(
    parameter int SETTLE_CYC   = rsd_pkg::SETTLE_CYCLES,
    parameter int PERIOD_CHARS = rsd_pkg::RC_PERIOD_CHARS,
    parameter int REF_TIMEOUT  = rsd_pkg::REF_TIMEOUT_CYCLES
) (
    input  wire logic                               mclk,
    input  wire logic                               rst,
    input  wire logic [rsd_pkg::ADDR_W-1:0]         reg_addr,
    input  wire logic [rsd_pkg::DATA_W-1:0]         reg_wdata,
    input  wire logic                               reg_wr,
    input  wire logic                               reg_rd,
    output logic      [rsd_pkg::DATA_W-1:0]         reg_rdata,
    input  wire logic [rsd_pkg::NUM_CH-1:0]         input_select,
    input  wire logic [rsd_pkg::NUM_CH-1:0]         serial_input_primary,
    input  wire logic [rsd_pkg::NUM_CH-1:0]         serial_input_alternate,
    input  wire logic [rsd_pkg::NUM_CH-1:0][1:0]    amp_level_primary,
    input  wire logic [rsd_pkg::NUM_CH-1:0][1:0]    amp_level_alternate,
    input  wire logic [rsd_pkg::NUM_CH-1:0]         bit_strobe,
    input  wire logic [rsd_pkg::NUM_CH-1:0]         training_clock,
    input  wire logic [rsd_pkg::NUM_CH-1:0][1:0]    speed_range_select,
    input  wire logic [rsd_pkg::NUM_CH-1:0]         receiver_inhibit,
    output logic      [rsd_pkg::NUM_CH-1:0]         cdr_data,
    output logic      [rsd_pkg::NUM_CH-1:0]         char_strobe,
    output logic      [rsd_pkg::NUM_CH-1:0]         track_training,
    output logic      [rsd_pkg::NUM_CH-1:0]         link_fault_n
);
    import rsd_pkg::*;

    localparam int SW = $clog2(SETTLE_CYC + 1);
    localparam int BW = $clog2(BITS_PER_CHAR);
    localparam logic [BW-1:0] BIT_LAST = BW'(BITS_PER_CHAR - 1);

    ////////////////////////////////////////////////////////////////////
    // Decoding shared by the channels.

    function automatic logic amp_pass(input logic [1:0] level,
                                      input logic [1:0] thr);
        // With the detector off, amplitude never blocks the link.
        amp_pass = (thr == THR_OFF) || (level >= thr);
    endfunction : amp_pass

    function automatic logic range_reserved(input logic [1:0] spd,
                                            input logic       half);
        range_reserved = (spd == SPD_LOW) && half;
    endfunction : range_reserved

    ////////////////////////////////////////////////////////////////////
    // Configuration register.

    logic [NUM_CH-1:0] power_r;
    logic [NUM_CH-1:0] half_rate_r;
    logic [1:0]        threshold_r;
    rsd_ch_cfg_t       ch_cfg [NUM_CH];
    rsd_ch_stat_t      ch_stat [NUM_CH];

    always_ff @(posedge mclk) begin
        if (rst) begin
            power_r     <= CFG_RESET[CFG_POWER_LSB +: NUM_CH];
            half_rate_r <= CFG_RESET[CFG_RATE_LSB +: NUM_CH];
            threshold_r <= CFG_RESET[CFG_THR_LSB +: 2];
        end else if (reg_wr && reg_addr == ADDR_CFG) begin
            power_r     <= reg_wdata[CFG_POWER_LSB +: NUM_CH];
            half_rate_r <= reg_wdata[CFG_RATE_LSB +: NUM_CH];
            threshold_r <= reg_wdata[CFG_THR_LSB +: 2];
        end
    end

    // Read data stands only in the cycle after the read strobe.
    always_ff @(posedge mclk) begin
        if (rst || !reg_rd) begin
            reg_rdata <= '0;
        end else begin
            unique case (reg_addr)
                ADDR_CFG: begin
                    reg_rdata <= '0;
                    reg_rdata[CFG_POWER_LSB +: NUM_CH] <= power_r;
                    reg_rdata[CFG_RATE_LSB +: NUM_CH]  <= half_rate_r;
                    reg_rdata[CFG_THR_LSB +: 2]        <= threshold_r;
                end
                ADDR_STAT0: begin
                    reg_rdata <= DATA_W'(ch_stat[0]);
                end
                ADDR_STAT1: begin
                    reg_rdata <= DATA_W'(ch_stat[1]);
                end
                default: begin
                    reg_rdata <= '0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Per-channel monitoring.

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        logic          sel_data;
        logic [1:0]    sel_level;
        logic          amp_ok;
        logic          dens_fault;
        logic          forced;
        logic          ref_ok;
        logic          reserved;
        logic          settling;
        logic          sig_valid;
        logic          chr;
        logic          power_q_r;
        logic [BW-1:0] bit_cnt_r;
        logic [SW-1:0] settle_r;

        assign ch_cfg[c].power     = power_r[c];
        assign ch_cfg[c].half_rate = half_rate_r[c];

        assign sel_data  = input_select[c] ? serial_input_alternate[c]
                                           : serial_input_primary[c];
        assign sel_level = input_select[c] ? amp_level_alternate[c]
                                           : amp_level_primary[c];
        assign amp_ok    = amp_pass(sel_level, threshold_r);
        assign reserved  = range_reserved(speed_range_select[c],
                                          ch_cfg[c].half_rate);

        always_ff @(posedge mclk) begin
            if (rst) begin
                cdr_data[c] <= 1'b0;
            end else if (ch_cfg[c].power && bit_strobe[c]) begin
                cdr_data[c] <= sel_data;
            end
        end

        // Recovered character clock: one enable per ten bit strobes.
        always_ff @(posedge mclk) begin
            if (rst || !ch_cfg[c].power) begin
                bit_cnt_r <= '0;
            end else if (bit_strobe[c]) begin
                bit_cnt_r <= (bit_cnt_r == BIT_LAST) ? '0
                                                     : bit_cnt_r + 1'b1;
            end
        end

        assign chr = ch_cfg[c].power && bit_strobe[c] &&
                     (bit_cnt_r == BIT_LAST);
        assign char_strobe[c] = chr;

        rsd_density_check #(
            .MAX_BITS      (DENSITY_MAX_BITS)
        ) u_density (
            .mclk          (mclk),
            .rst           (rst),
            .enable        (ch_cfg[c].power),
            .bit_strobe    (bit_strobe[c]),
            .data_bit      (sel_data),
            .density_fault (dens_fault)
        );

        rsd_range_ctrl #(
            .PERIOD_CHARS  (PERIOD_CHARS),
            .REF_TIMEOUT   (REF_TIMEOUT)
        ) u_range (
            .mclk          (mclk),
            .rst           (rst),
            .enable        (ch_cfg[c].power),
            .half_rate     (ch_cfg[c].half_rate),
            .char_strobe   (chr),
            .training_tick (training_clock[c]),
            .forced        (forced),
            .ref_present   (ref_ok)
        );

        assign track_training[c] = forced;

        // Re-enable opens a settling span in which the fault is held, so
        // nothing downstream sees the indeterminate start-up state.
        always_ff @(posedge mclk) begin
            if (rst) begin
                power_q_r <= 1'b0;
            end else begin
                power_q_r <= ch_cfg[c].power;
            end
        end

        always_ff @(posedge mclk) begin
            if (rst || !ch_cfg[c].power) begin
                settle_r <= '0;
            end else if (!power_q_r) begin
                settle_r <= SW'(SETTLE_CYC);
            end else if (settle_r != '0) begin
                settle_r <= settle_r - 1'b1;
            end
        end

        assign settling  = (settle_r != '0);
        assign sig_valid = amp_ok && !dens_fault && !forced &&
                           ch_cfg[c].power && ref_ok &&
                           !receiver_inhibit[c] && !reserved &&
                           !settling;

        // A powered-down channel has no recovered clock, so its fault
        // is applied at once rather than waiting for a character edge.
        always_ff @(posedge mclk) begin
            if (rst || !ch_cfg[c].power) begin
                link_fault_n[c] <= 1'b0;
            end else if (chr) begin
                link_fault_n[c] <= sig_valid;
            end
        end

        assign ch_stat[c].link_fault_n  = link_fault_n[c];
        assign ch_stat[c].amp_ok        = amp_ok;
        assign ch_stat[c].density_fault = dens_fault;
        assign ch_stat[c].forced        = forced;
        assign ch_stat[c].ref_present   = ref_ok;
        assign ch_stat[c].settling      = settling;
        assign ch_stat[c].cfg_reserved  = reserved;
    end : g_ch

endmodule : rsd_link_monitor

`default_nettype wire

// >>> rsd_link_monitor_bench.sv
`default_nettype none

module rsd_link_monitor_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import rsd_pkg::*;
    localparam int WIN = 64;
    localparam int CH  = 20;
    logic                   mclk;
    logic                   rst;
    logic [ADDR_W-1:0]      reg_addr;
    logic [DATA_W-1:0]      reg_wdata;
    logic                   reg_wr;
    logic                   reg_rd;
    logic [DATA_W-1:0]      reg_rdata;
    logic [1:0]             input_select;
    logic [1:0]             serial_input_primary;
    logic [1:0]             serial_input_alternate;
    logic [1:0][1:0]        amp_level_primary;
    logic [1:0][1:0]        amp_level_alternate;
    logic [1:0]             bit_strobe;
    logic [1:0]             training_clock;
    logic [1:0][1:0]        speed_range_select;
    logic [1:0]             receiver_inhibit;
    logic [1:0]             cdr_data;
    logic [1:0]             char_strobe;
    logic [1:0]             track_training;
    logic [1:0]             link_fault_n;
    logic                   hold;
    logic [4:0]             tick_div;
    int                     err_total;
    int                     n_compared;
    int                     n_char0;
    int                     c0;

    rsd_link_monitor #(.SETTLE_CYC(20), .PERIOD_CHARS(WIN)) uut (
        .mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .input_select, .serial_input_primary, .serial_input_alternate,
        .amp_level_primary, .amp_level_alternate, .bit_strobe,
        .training_clock, .speed_range_select, .receiver_inhibit,
        .cdr_data, .char_strobe, .track_training, .link_fault_n);
    rsd_tx_model partner (
        .mclk, .rst, .hold, .tick_div, .bit_strobe, .training_clock,
        .line_primary(serial_input_primary),
        .line_alternate(serial_input_alternate));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t ns: saw %h, expected %h", $time, got, exp);
        end
    endtask : chk

    // Bus tasks start and end just after a rising edge; the trailing idle
    // edge keeps a strobe from being assigned twice in one time step.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
        @(posedge mclk);
    endtask : rd

    task automatic wt(input int chars);
        repeat (chars * CH) @(posedge mclk);
    endtask : wt

    // Expected value is {track_training, link_fault_n}.
    task automatic ck(input logic [3:0] exp);
        @(negedge mclk);
        chk(32'({track_training, link_fault_n}), 32'(exp));
        @(posedge mclk);
    endtask : ck

    function automatic logic [31:0] cf(input logic [1:0] p, h, t);
        return (32'(p) << CFG_POWER_LSB) | (32'(h) << CFG_RATE_LSB) |
               (32'(t) << CFG_THR_LSB);
    endfunction : cf

    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // Character strobes of channel 0, counted to check the window length.
    always @(posedge mclk) begin
        if (char_strobe[0]) begin
            n_char0 <= n_char0 + 1;
        end
    end

    initial begin
        repeat (40000) @(posedge mclk);
        err_total++;
        $display("Error at %0t ns: watchdog expired", $time);
        give_verdict();
    end

    initial begin
        rst = 1'b1;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        input_select = 2'b00;
        amp_level_primary = '1;
        amp_level_alternate = '1;
        speed_range_select = {SPD_HIGH, SPD_HIGH};
        receiver_inhibit = 2'b00;
        hold = 1'b0;
        tick_div = 5'h0a;
        err_total = 0;
        n_compared = 0;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(ADDR_CFG, CFG_RESET);
        rd(8'h0c, 32'h0);
        ck(4'h0);
        wr(ADDR_CFG, cf(2'b11, 2'b00, THR_LOW));
        wt(3 * WIN);
        ck(4'h3);
        rd(ADDR_STAT0, 32'h13);
        wr(ADDR_STAT0, 32'hffff_ffff);
        rd(ADDR_STAT0, 32'h13);
        $display("test lock done");
        amp_level_primary <= {2'h1, 2'h1};
        for (int t = 0; t < 4; t++) begin
            wr(ADDR_CFG, cf(2'b11, 2'b00, 2'(t)));
            wt(3);
            ck(t < 2 ? 4'h3 : 4'h0);
        end
        $display("test threshold done");
        amp_level_primary <= '0;
        wr(ADDR_CFG, cf(2'b11, 2'b00, THR_MID));
        input_select <= 2'b10;
        wt(3);
        ck(4'h2);
        input_select <= 2'b01;
        wt(3);
        ck(4'h1);
        input_select <= 2'b00;
        amp_level_primary <= '1;
        hold <= 1'b1;
        wt(8);
        ck(4'h0);
        hold <= 1'b0;
        wt(2);
        ck(4'h3);
        receiver_inhibit <= 2'b01;
        wt(2);
        ck(4'h2);
        receiver_inhibit <= 2'b00;
        $display("test monitors done");
        tick_div <= 5'h0b;
        wt(2 * WIN + 2);
        ck(4'hc);
        tick_div <= 5'h0a;
        wt(3 * WIN);
        ck(4'h3);
        wr(ADDR_CFG, cf(2'b11, 2'b11, THR_LOW));
        tick_div <= 5'h14;
        c0 = n_char0;
        wt(3 * WIN);
        chk(32'(n_char0 - c0), 32'(3 * WIN));
        ck(4'h3);
        speed_range_select <= {SPD_HIGH, SPD_LOW};
        wt(2);
        ck(4'h2);
        speed_range_select <= {SPD_HIGH, SPD_HIGH};
        $display("test range done");
        wr(ADDR_CFG, cf(2'b01, 2'b11, THR_LOW));
        wt(1);
        ck(4'h1);
        wr(ADDR_CFG, cf(2'b11, 2'b11, THR_LOW));
        rd(ADDR_STAT1, 32'h32);
        wt(3 * WIN);
        ck(4'h3);
        $display("test power done");
        give_verdict();
    end

endmodule : rsd_link_monitor_bench

`default_nettype wire

// >>> rsd_link_monitor_sva.sv
`default_nettype none

module rsd_link_monitor_sva (
    input wire logic                       mclk,
    input wire logic                       rst,
    input wire logic [rsd_pkg::NUM_CH-1:0] input_select,
    input wire logic [rsd_pkg::NUM_CH-1:0] serial_input_primary,
    input wire logic [rsd_pkg::NUM_CH-1:0] serial_input_alternate,
    input wire logic [rsd_pkg::NUM_CH-1:0] bit_strobe,
    input wire logic [rsd_pkg::NUM_CH-1:0] receiver_inhibit,
    input wire logic [rsd_pkg::NUM_CH-1:0] cdr_data,
    input wire logic [rsd_pkg::NUM_CH-1:0] char_strobe,
    input wire logic [rsd_pkg::NUM_CH-1:0] track_training,
    input wire logic [rsd_pkg::NUM_CH-1:0] link_fault_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       sel0;
    logic       last_r;
    logic [7:0] run_r;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    // Equal-bit run on the selected line; a reselect restarts nothing, so
    // the bound used below keeps one bit of margin.
    assign sel0 = input_select[0] ? serial_input_alternate[0]
                                  : serial_input_primary[0];
    always_ff @(posedge mclk) begin
        if (rst) begin
            run_r  <= 8'h00;
            last_r <= 1'b0;
        end else if (bit_strobe[0]) begin
            last_r <= sel0;
            if (sel0 == last_r && run_r != 8'hff) begin
                run_r <= run_r + 8'h01;
            end else begin
                run_r <= 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_route_selected: assert property (
        bit_strobe[0] && char_strobe[0] |=> cdr_data[0] == $past(sel0))
        else $error("recovered bit is not the selected line");
    a_inhibit_fault: assert property (
        receiver_inhibit[0] && char_strobe[0] |=> !link_fault_n[0])
        else $error("inhibited channel 0 shows a valid signal");
    a_inhibit_ch1: assert property (
        receiver_inhibit[1] && char_strobe[1] |=> !link_fault_n[1])
        else $error("inhibited channel 1 shows a valid signal");
    a_rise_on_char: assert property (
        $rose(link_fault_n[0]) |-> $past(char_strobe[0]))
        else $error("channel 0 fault released off the character clock");
    a_rise_ch1: assert property (
        $rose(link_fault_n[1]) |-> $past(char_strobe[1]))
        else $error("channel 1 fault released off the character clock");
    a_no_transition: assert property (
        char_strobe[0] && run_r > 8'h3e |=> !link_fault_n[0])
        else $error("long run without transition not reported");
    a_forced_fault: assert property (
        track_training[0] && char_strobe[0] |=> !link_fault_n[0])
        else $error("valid signal shown while tracking training clock");
    a_force_at_window: assert property (
        $rose(track_training[0]) |-> $past(char_strobe[0]))
        else $error("oscillator forced away from a character boundary");

endmodule : rsd_link_monitor_sva

bind rsd_link_monitor rsd_link_monitor_sva u_sva (
    .mclk, .rst, .input_select, .serial_input_primary,
    .serial_input_alternate, .bit_strobe, .receiver_inhibit, .cdr_data,
    .char_strobe, .track_training, .link_fault_n
);

`default_nettype wire

// >>> rsd_pkg.sv
`default_nettype none

package rsd_pkg;

    localparam int NUM_CH = 2;

    // Register map, byte addresses on the plain register port.
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam logic [7:0]  ADDR_CFG      = 8'h00;
    localparam logic [7:0]  ADDR_STAT0    = 8'h04;
    localparam logic [7:0]  ADDR_STAT1    = 8'h08;

    // Field positions in the configuration register.
    localparam int CFG_POWER_LSB = 0;
    localparam int CFG_RATE_LSB  = 2;
    localparam int CFG_THR_LSB   = 4;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;

    // Amplitude threshold encodings.
    localparam logic [1:0] THR_OFF  = 2'h0;
    localparam logic [1:0] THR_LOW  = 2'h1;
    localparam logic [1:0] THR_MID  = 2'h2;
    localparam logic [1:0] THR_HIGH = 2'h3;

    // Three-level speed range input, coded on two wires.
    localparam logic [1:0] SPD_LOW  = 2'h0;
    localparam logic [1:0] SPD_MID  = 2'h1;
    localparam logic [1:0] SPD_HIGH = 2'h2;

    // Line and recovery constants.
    localparam int BITS_PER_CHAR    = 10;
    localparam int DENSITY_MAX_BITS = 60;
    localparam int RC_PERIOD_CHARS  = 4096;
    localparam int PPM_LIMIT        = 1500;
    localparam int PPM_SCALE        = 1000000;
    localparam int RC_EXP_FULL      = RC_PERIOD_CHARS;
    localparam int RC_EXP_HALF      = RC_PERIOD_CHARS / 2;
    localparam int RC_TOL_FULL      = RC_EXP_FULL * PPM_LIMIT / PPM_SCALE;
    localparam int RC_TOL_HALF      = RC_EXP_HALF * PPM_LIMIT / PPM_SCALE;

    // Timing at the system clock.
    localparam int CLK_PERIOD_NS    = 5;
    localparam int SETTLE_TIME_US   = 2000;
    localparam int SETTLE_CYCLES    =
        SETTLE_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int REF_TIMEOUT_CYCLES = 256;

    typedef struct packed {
        logic       power;
        logic       half_rate;
    } rsd_ch_cfg_t;

    typedef struct packed {
        logic       cfg_reserved;
        logic       settling;
        logic       ref_present;
        logic       forced;
        logic       density_fault;
        logic       amp_ok;
        logic       link_fault_n;
    } rsd_ch_stat_t;

endpackage : rsd_pkg

`default_nettype wire

// >>> rsd_range_ctrl.sv
`default_nettype none

module rsd_range_ctrl #(
    parameter int PERIOD_CHARS = rsd_pkg::RC_PERIOD_CHARS,
    parameter int REF_TIMEOUT  = rsd_pkg::REF_TIMEOUT_CYCLES
) (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic enable,
    input  wire logic half_rate,
    input  wire logic char_strobe,
    input  wire logic training_tick,
    output logic      forced,
    output logic      ref_present
);
    import rsd_pkg::*;

    localparam int CW = $clog2(PERIOD_CHARS);
    localparam int TW = CW + 2;
    localparam int RW = $clog2(REF_TIMEOUT + 1);
    localparam logic [CW-1:0] CHAR_LAST = CW'(PERIOD_CHARS - 1);
    localparam logic [TW-1:0] EXP_F = TW'(PERIOD_CHARS);
    localparam logic [TW-1:0] EXP_H = TW'(PERIOD_CHARS / 2);
    localparam logic [TW-1:0] TOL_F =
        TW'(PERIOD_CHARS * PPM_LIMIT / PPM_SCALE);
    localparam logic [TW-1:0] TOL_H =
        TW'((PERIOD_CHARS / 2) * PPM_LIMIT / PPM_SCALE);
    localparam logic [RW-1:0] REF_MAX = RW'(REF_TIMEOUT);

    logic [CW-1:0] char_cnt_r;
    logic [TW-1:0] trg_cnt_r;
    logic [RW-1:0] ref_age_r;
    logic [TW-1:0] exp_cnt;
    logic [TW-1:0] tol_cnt;
    logic          in_range;

    ////////////////////////////////////////////////////////////////////
    // Expected training ticks per window depend on the training rate.

    assign exp_cnt  = half_rate ? EXP_H : EXP_F;
    assign tol_cnt  = half_rate ? TOL_H : TOL_F;
    assign in_range = (trg_cnt_r >= exp_cnt - tol_cnt) &&
                      (trg_cnt_r <= exp_cnt + tol_cnt);

    always_ff @(posedge mclk) begin
        if (rst || !enable) begin
            char_cnt_r <= '0;
        end else if (char_strobe) begin
            char_cnt_r <= char_cnt_r + 1'b1;
        end
    end

    // A tick landing on the window edge starts the next window's count.
    always_ff @(posedge mclk) begin
        if (rst || !enable) begin
            trg_cnt_r <= '0;
        end else if (char_strobe && char_cnt_r == CHAR_LAST) begin
            trg_cnt_r <= training_tick ? TW'(1) : '0;
        end else if (training_tick && trg_cnt_r != '1) begin
            trg_cnt_r <= trg_cnt_r + 1'b1;
        end
    end

    // Forced tracking is entered only at a window boundary and left there or at disable, so
    // the oscillator always gets one full window to settle either way.
    always_ff @(posedge mclk) begin
        if (rst || !enable) begin
            forced <= 1'b0;
        end else if (char_strobe && char_cnt_r == CHAR_LAST) begin
            forced <= !in_range;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || !enable || training_tick) begin
            ref_age_r <= '0;
        end else if (ref_age_r != REF_MAX) begin
            ref_age_r <= ref_age_r + 1'b1;
        end
    end

    assign ref_present = enable && (ref_age_r != REF_MAX);

endmodule : rsd_range_ctrl

`default_nettype wire

// >>> rsd_tx_model.sv
`default_nettype none

module rsd_tx_model (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       hold,
    input  wire logic [4:0] tick_div,
    output logic      [1:0] bit_strobe,
    output logic      [1:0] line_primary,
    output logic      [1:0] line_alternate,
    output logic      [1:0] training_clock
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       phase_r;
    logic [3:0] pat_r;
    logic [4:0] tick_cnt_r;

    ////////////////////////////////////////////////////////////////////////
    // One bit every two clocks; hold freezes the line to starve transitions.
    always_ff @(posedge mclk) begin
        if (rst) begin
            phase_r <= 1'b0;
            pat_r   <= 4'h0;
        end else begin
            phase_r <= !phase_r;
            if (phase_r && !hold) begin
                pat_r <= pat_r + 4'h1;
            end
        end
    end
    assign bit_strobe     = {2{phase_r}};
    assign line_primary   = {2{pat_r[1]}};
    assign line_alternate = {2{~pat_r[0]}};

    ////////////////////////////////////////////////////////////////////////
    // Training tick counted in line bits, so 10 is exactly character rate.
    always_ff @(posedge mclk) begin
        if (rst || tick_div == 5'h00) begin
            tick_cnt_r <= 5'h00;
        end else if (phase_r) begin
            if (tick_cnt_r >= tick_div - 5'h01) begin
                tick_cnt_r <= 5'h00;
            end else begin
                tick_cnt_r <= tick_cnt_r + 5'h01;
            end
        end
    end
    assign training_clock = {2{phase_r && tick_cnt_r == 5'h00 &&
                               tick_div != 5'h00}};

endmodule : rsd_tx_model

`default_nettype wire
